// File: logic/prs_top.sv
// power table, wake and sleep control and power setting output
`timescale 1ns/100ps
module prs_top
  import prs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // chip select pin
  input wire logic chip_select_active_low,
  // command strobes from the serial decoder
  input wire logic power_down_strobe,
  // table write from the serial decoder
  input wire prs_wr_t table_wr,
  // configuration
  input wire logic [2:0] pa_index_limit,
  input wire prs_mod_t mod,
  // serial data output pin
  output logic serial_out,
  output logic serial_out_oe,
  // power control
  output logic core_power_on,
  output logic xosc_on,
  // amplifier drive
  output logic [2:0] pa_index,
  output logic [7:0] pa_setting
);

  // ************************************************************
  // reset release and pin synchroniser
  // ************************************************************
  logic rst_meta_reg;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n <= rst_meta_reg;
    end
  end

  logic cs_meta_reg;
  logic cs_sync_reg;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
    end else begin
      cs_meta_reg <= chip_select_active_low;
      cs_sync_reg <= cs_meta_reg;
    end
  end

  // ************************************************************
  // power-down and wake
  // ************************************************************
  logic pd_pending_reg;
  logic power_reg;
  logic sleep_go;
  logic wake_go;

  assign sleep_go = pd_pending_reg && cs_sync_reg && power_reg;
  assign wake_go = !cs_sync_reg && !power_reg;

  // a new strobe in the cycle the pending flag clears is kept
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pd_pending_reg <= 1'b0;
    end else if (power_down_strobe && power_reg) begin
      pd_pending_reg <= 1'b1;
    end else if (sleep_go) begin
      pd_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      power_reg <= 1'b1;
    end else if (wake_go) begin
      power_reg <= 1'b1;
    end else if (sleep_go) begin
      power_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      core_power_on <= 1'b1;
      xosc_on <= 1'b1;
    end else begin
      core_power_on <= power_reg;
      xosc_on <= power_reg;
    end
  end

  // ************************************************************
  // ready indication on the serial output
  // ************************************************************
  logic [7:0] ready_cnt_reg;
  logic ready_done;

  assign ready_done = ready_cnt_reg == PRS_READY_COUNT;

  // counts oscillator start-up from chip select low with power on
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ready_cnt_reg <= 8'h00;
    end else if (cs_sync_reg || !power_reg) begin
      ready_cnt_reg <= 8'h00;
    end else if (!ready_done) begin
      ready_cnt_reg <= 8'(ready_cnt_reg + 8'h01);
    end
  end

  // drive low only once ready; released while deselected
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out <= 1'b0;
      serial_out_oe <= ready_done && !cs_sync_reg && power_reg;
    end
  end

  // ************************************************************
  // power level table
  // ************************************************************
  logic [7:0] table_reg [PRS_TABLE_DEPTH];
  logic [2:0] wr_index;

  // single access always lands on entry 0
  assign wr_index = table_wr.burst ? table_wr.index : PRS_INDEX_ZERO;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      table_reg[0] <= PRS_ENTRY0_RESET;
      for (int i = 1; i < PRS_TABLE_DEPTH; i++) begin
        table_reg[i] <= PRS_ENTRY_CLEAR;
      end
    end else begin
      for (int i = 1; i < PRS_TABLE_DEPTH; i++) begin
        if (sleep_go) begin
          table_reg[i] <= PRS_ENTRY_CLEAR;
        end
      end
      if (table_wr.en) begin
        table_reg[wr_index] <= table_wr.data;
      end
    end
  end

  // ************************************************************
  // index counter and amplifier drive
  // ************************************************************
  prs_shaper u_shaper (
    .sys_clk(sys_clk),
    .rst_sync_n(rst_sync_n),
    .mod(mod),
    .pa_index_limit(pa_index_limit),
    .index_reg(pa_index)
  );

  // selected entry drives the amplifier through a register, one cycle after the index
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pa_setting <= PRS_ENTRY0_RESET;
    end else begin
      pa_setting <= table_reg[pa_index];
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_single_entry0: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n)
    table_wr.en && !table_wr.burst && !sleep_go |=>
    table_reg[0] == $past(table_wr.data) &&
    table_reg[1] == $past(table_reg[1]))
    else $error("single write missed entry 0");

  a_burst_entry: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n)
    table_wr.en && table_wr.burst |=>
    table_reg[$past(table_wr.index)] == $past(table_wr.data))
    else $error("burst write missed its entry");

  a_sleep_clear: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n)
    sleep_go && !table_wr.en |=> table_reg[7] == 8'h00 &&
    table_reg[1] == 8'h00 && table_reg[0] == $past(table_reg[0]))
    else $error("sleep entry did not clear the table");

  a_wake_on_cs: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n)
    !cs_sync_reg |-> ##2 core_power_on && xosc_on)
    else $error("chip select low did not restore power");

  a_power_off: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n)
    pd_pending_reg && cs_sync_reg && power_reg |-> ##2 !core_power_on)
    else $error("power stayed on after deselect");

  a_stay_on: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n)
    !pd_pending_reg && power_reg |=> power_reg)
    else $error("power dropped without strobe");

  a_so_ready: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n)
    $rose(serial_out_oe) |-> !serial_out &&
    $past(ready_cnt_reg) == PRS_READY_COUNT)
    else $error("serial output driven before ready");

  a_so_release: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n)
    cs_sync_reg |=> !serial_out_oe)
    else $error("serial output driven while deselected");

  // the index must hold over the lookup cycle, or a tick moves it
  a_setting_map: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n)
    !table_wr.en && !sleep_go ##1 $stable(pa_index) |->
    pa_setting == table_reg[pa_index])
    else $error("amplifier setting does not match entry");

  c_ramp_top: cover property (@(posedge sys_clk) disable iff (!rst_sync_n)
    pa_index == 3'h7 && !mod.ask_mode);
  c_ask_shape: cover property (@(posedge sys_clk) disable iff (!rst_sync_n)
    mod.ask_mode && pa_index == 3'h0 ##1 pa_index == 3'h1);
  c_sleep_wake: cover property (@(posedge sys_clk) disable iff (!rst_sync_n)
    sleep_go ##[1:200] wake_go);
  c_so_low: cover property (@(posedge sys_clk) disable iff (!rst_sync_n)
    $rose(serial_out_oe));

endmodule // prs_top

// File: inc/prs_pkg.sv
// constants and types for the power ramp and shaping block
// ************************************************************
// How it works
// - eight-entry power table, 3-bit index limit picks the steady entry
// - ramping walks every entry from 0 up to the limit and back down
// - chip select low turns on core regulator and crystal oscillator
// - serial output goes low when ready; no clock edge before that
// - after power-down strobe, power drops at chip select high, returns at low
// - table entry 0 resets to 0xc6
// - single access reaches entry 0 only; burst reaches the others
// - sleep keeps entry 0 and clears all other entries
// - amplitude shaping counter counts up on one, down on zero
// - shaping counter steps at eight times the symbol rate
// - counter saturates at index limit going up and zero going down
// - counter value is the table index selecting output power
// ************************************************************
package prs_pkg;

  localparam int PRS_TABLE_DEPTH = 8;
  localparam logic [7:0] PRS_ENTRY0_RESET = 8'hc6;
  localparam logic [7:0] PRS_ENTRY_CLEAR = 8'h00;
  localparam logic [2:0] PRS_INDEX_ZERO = 3'h0;
  localparam logic [2:0] PRS_INDEX_STEP = 3'h1;

  // oscillator start-up before the serial output is driven low
  localparam int PRS_CLK_PERIOD_NS = 10;
  localparam int PRS_XOSC_START_NS = 200;
  localparam int PRS_XOSC_START_CYC =
    (PRS_XOSC_START_NS + PRS_CLK_PERIOD_NS - 1) / PRS_CLK_PERIOD_NS;
  localparam logic [7:0] PRS_READY_COUNT = 8'(PRS_XOSC_START_CYC);

  typedef struct packed {
    logic en;
    logic burst;
    logic [2:0] index;
    logic [7:0] data;
  } prs_wr_t;

  typedef struct packed {
    logic ask_mode;
    logic tx_active;
    logic tx_symbol;
    logic shape_tick;
  } prs_mod_t;

endpackage

// File: logic/prs_shaper.sv
// up/down index counter for power ramping and amplitude shaping
`timescale 1ns/100ps
module prs_shaper
  import prs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_sync_n,
  // control
  input wire prs_mod_t mod,
  input wire logic [2:0] pa_index_limit,
  // index out
  output logic [2:0] index_reg
);

  logic count_up;
  logic [2:0] index_next;

  // keying picks the direction, otherwise the transmit window does
  assign count_up = mod.ask_mode ? mod.tx_symbol : mod.tx_active;

  always_comb begin
    index_next = index_reg;
    if (index_reg > pa_index_limit) begin
      index_next = pa_index_limit;
    end else if (mod.shape_tick) begin
      if (count_up && index_reg != pa_index_limit) begin
        index_next = 3'(index_reg + PRS_INDEX_STEP);
      end else if (!count_up && index_reg != PRS_INDEX_ZERO) begin
        index_next = 3'(index_reg - PRS_INDEX_STEP);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      index_reg <= PRS_INDEX_ZERO;
    end else begin
      index_reg <= index_next;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_count_up: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    mod.shape_tick && count_up && index_reg < pa_index_limit ##1
    $stable(pa_index_limit) |-> index_reg == $past(index_reg) + 3'h1)
    else $error("counter did not step up");
  a_count_down: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    mod.shape_tick && !count_up && index_reg != 3'h0 &&
    index_reg <= pa_index_limit |=> index_reg == $past(index_reg) - 3'h1)
    else $error("counter did not step down");
  a_sat_limit: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    $stable(pa_index_limit) |-> index_reg <= pa_index_limit)
    else $error("counter passed the index limit");
  a_hold_no_tick: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    !mod.shape_tick && index_reg <= pa_index_limit |=> $stable(index_reg))
    else $error("counter moved without a tick");

endmodule // prs_shaper

// File: tb/prs_mcu_model.sv
// microcontroller model driving chip select, strobes and table writes
`timescale 1ns/100ps
module prs_mcu_model
  import prs_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // device pins
  input wire logic serial_out,
  input wire logic serial_out_oe,
  output logic chip_select_active_low,
  output logic power_down_strobe,
  output prs_wr_t table_wr
);
  logic so_line;

  // released line idles high, the inverse of the only level driven
  assign so_line = serial_out_oe ? serial_out : 1'b1;

  initial begin
    chip_select_active_low = 1'b1;
    power_down_strobe = 1'b0;
    table_wr = '{en: 1'b0, burst: 1'b0, index: 3'h0, data: 8'h00};
  end

  // one byte per enable; index and data then show the inverse of the last value, burst holds
  task automatic put(input logic burst, input logic [2:0] idx,
                     input logic [7:0] data);
    @(posedge sys_clk);
    table_wr <= '{en: 1'b1, burst: burst, index: idx, data: data};
    @(posedge sys_clk);
    table_wr <= '{en: 1'b0, burst: burst, index: ~idx, data: ~data};
  endtask

  // restricted levels only; zero level in entry 0, written last, single
  task automatic load_table();
    int k;
    for (k = 1; k < 8; k++) begin
      put(1'b1, 3'(k), 8'(8'h30 + 2 * k));
    end
    put(1'b0, 3'h6, 8'h30);
  endtask

  // select, then hold off any serial clock until the output goes low
  task automatic wake(output bit ready);
    int n;
    @(posedge sys_clk);
    chip_select_active_low <= 1'b0;
    ready = 1'b0;
    for (n = 0; n < 64 && !ready; n++) begin
      @(posedge sys_clk);
      #1;
      ready = (so_line === 1'b0);
    end
  endtask

  task automatic power_down();
    @(posedge sys_clk);
    power_down_strobe <= 1'b1;
    @(posedge sys_clk);
    power_down_strobe <= 1'b0;
    chip_select_active_low <= 1'b1;
  endtask
endmodule // prs_mcu_model

// File: tb/prs_top_tb.sv
// self-checking bench for the power ramp and shaping block
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module prs_top_tb
  import prs_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] pa_index_limit = 3'h0;
  prs_mod_t mod = '0;
  logic chip_select_active_low, power_down_strobe;
  prs_wr_t table_wr;
  logic serial_out, serial_out_oe, core_power_on, xosc_on;
  logic [2:0] pa_index;
  logic [7:0] pa_setting;
  logic [7:0] exp_tab [8];
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int idx = 0;
  int k;
  bit ready;

  always #5 sys_clk = ~sys_clk;

  prs_mcu_model i_mcu (.sys_clk(sys_clk), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe),
    .chip_select_active_low(chip_select_active_low),
    .power_down_strobe(power_down_strobe), .table_wr(table_wr));

  prs_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .chip_select_active_low(chip_select_active_low),
    .power_down_strobe(power_down_strobe), .table_wr(table_wr),
    .pa_index_limit(pa_index_limit), .mod(mod), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .core_power_on(core_power_on),
    .xosc_on(xosc_on), .pa_index(pa_index), .pa_setting(pa_setting));

  task automatic end_of_test();
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic set_mode(input logic ask, act, sym, input logic [2:0] lim);
    @(posedge sys_clk);
    mod <= '{ask, act, sym, 1'b0};
    pa_index_limit <= lim;
  endtask

  // one shaping tick, then index and selected setting
  task automatic tick(input logic [2:0] e);
    @(posedge sys_clk);
    mod.shape_tick <= 1'b1;
    @(posedge sys_clk);
    mod.shape_tick <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK(pa_index, e)
    `CHK(pa_setting, exp_tab[e])
  endtask

  // expected index saturates at the limit and at zero
  task automatic sweep(input int n, input bit up, input int lim);
    int j;
    for (j = 0; j < n; j++) begin
      idx = up ? ((idx < lim) ? idx + 1 : idx) : ((idx > 0) ? idx - 1 : idx);
      tick(3'(idx));
    end
  endtask

  initial begin
    exp_tab[0] = 8'hc6;
    for (k = 1; k < 8; k++) exp_tab[k] = 8'h00;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(pa_setting, 8'hc6)
    `CHK(pa_index, 3'h0)
    `CHK(core_power_on, 1'b1)
    `CHK(serial_out_oe, 1'b0)
    i_mcu.wake(ready);
    `CHK(ready, 1'b1)
    `CHK(serial_out, 1'b0)
    `CHK(xosc_on, 1'b1)
    i_mcu.load_table();
    exp_tab[0] = 8'h30;
    for (k = 1; k < 8; k++) exp_tab[k] = 8'(8'h30 + 2 * k);
    set_mode(1'b0, 1'b1, 1'b0, 3'h0);
    sweep(2, 1'b1, 0);
    set_mode(1'b0, 1'b1, 1'b0, 3'h3);
    sweep(4, 1'b1, 3);
    set_mode(1'b0, 1'b0, 1'b0, 3'h3);
    sweep(4, 1'b0, 3);
    set_mode(1'b1, 1'b1, 1'b1, 3'h7);
    sweep(9, 1'b1, 7);
    repeat (5) @(posedge sys_clk);
    #1;
    `CHK(pa_index, 3'h7)
    set_mode(1'b1, 1'b1, 1'b0, 3'h7);
    sweep(3, 1'b0, 7);
    set_mode(1'b1, 1'b1, 1'b0, 3'h2);
    repeat (3) @(posedge sys_clk);
    #1;
    idx = 2;
    `CHK(pa_index, 3'h2)
    sweep(3, 1'b0, 2);
    i_mcu.power_down();
    repeat (6) @(posedge sys_clk);
    #1;
    `CHK(core_power_on, 1'b0)
    `CHK(xosc_on, 1'b0)
    `CHK(serial_out_oe, 1'b0)
    i_mcu.wake(ready);
    `CHK(ready, 1'b1)
    `CHK(core_power_on, 1'b1)
    `CHK(xosc_on, 1'b1)
    for (k = 1; k < 8; k++) exp_tab[k] = 8'h00;
    set_mode(1'b1, 1'b1, 1'b0, 3'h7);
    sweep(1, 1'b0, 7);
    set_mode(1'b1, 1'b1, 1'b1, 3'h7);
    sweep(8, 1'b1, 7);
    // reset in mid-run restores the table defaults
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(pa_setting, 8'hc6)
    `CHK(pa_index, 3'h0)
    `CHK(core_power_on, 1'b1)
    `CHK(serial_out_oe, 1'b0)
    idx = 0;
    sweep(1, 1'b1, 7);
    end_of_test();
  end
endmodule // prs_top_tb
